// ===== core/hcr_pkg.sv
// Package of register map, field layouts and reset values for the config bank
package hcr_pkg;

  localparam int HCR_NCH = 4;

  // Register map: per-channel block at base + stride * channel
  localparam logic [6:0] HCR_CH_STRIDE = 7'h08;
  localparam logic [2:0] HCR_OFF_CHAN_IRQ_STATUS = 3'h0;
  localparam logic [2:0] HCR_OFF_ISM = 3'h1;
  localparam logic [2:0] HCR_OFF_CHAN_STATUS = 3'h2;
  localparam logic [2:0] HCR_OFF_CHAN_COMMAND = 3'h3;
  localparam logic [2:0] HCR_OFF_MODE = 3'h4;
  localparam logic [2:0] HCR_OFF_RX_FRAME_BYTE_COUNT = 3'h5;
  localparam logic [2:0] HCR_OFF_TSR = 3'h6;
  localparam logic [6:0] HCR_ADDR_CHANNEL_VECTOR_STATUS = 7'h36;
  localparam logic [6:0] HCR_ADDR_CHANNEL_VECTOR_MASK = 7'h37;
  localparam logic [6:0] HCR_ADDR_CCR = 7'h3a;
  localparam logic [6:0] HCR_ADDR_ACR = 7'h3b;

  // Reset values
  localparam logic [7:0] HCR_RST_ZERO = 8'h00;
  localparam logic [7:0] HCR_RST_CHAN_STATUS = 8'h50;

  // Vector lanes on the data bus
  localparam logic [7:0] HCR_LANE_LO = 8'h0f;
  localparam logic [7:0] HCR_LANE_HI = 8'hf0;

  // Host bus styles picked by the latch-enable strap
  typedef enum logic [1:0] {
    HCR_STYLE_RWDS,
    HCR_STYLE_RDWR,
    HCR_STYLE_MUX
  } hcr_style_e;

  // Common configuration, bit 7 down to bit 0
  typedef struct packed {
    logic spare;
    logic vector_lane_sel;
    logic [1:0] frame_length_sel;
    logic clock_ratio_sel;
    logic driver_type_sel;
    logic [1:0] config_timing_sel;
  } hcr_ccr_s;

  // Address comparison control
  typedef struct packed {
    logic [3:0] per_channel_compare_en;
    logic [2:0] compare_address_sel;
    logic compare_accept_reject;
  } hcr_acr_s;

  // Per-channel mode
  typedef struct packed {
    logic receiver_active;
    logic channel_active;
    logic loopback_en;
    logic interframe_fill_sel;
    logic [1:0] channel_width_sel;
    logic [1:0] collision_mode_sel;
  } hcr_mode_s;

  // Serial data pin of one channel
  typedef struct packed {
    logic out;
    logic oe;
  } hcr_pin_s;

endpackage

// ===== core/hcr_regs.sv
// Configuration and status register bank of a four-channel HDLC controller
// Contract
// - Strap picks bus style; edge locks multiplexed
// - Seven address lines, eight data lines
// - Hardware reset zeroes configuration and command bits
// - After reset no interrupt, outputs floating
// - Channel status reads 50 hex after reset
// - Common config zero: TS, low lanes, push-pull
// - Reset: 257-512 bit frame, rate equals clock
// - Channel disabled after reset, data floating
// - Reset: 2-bit slots, receiver off, no loop
// - Unconditional transmit; mode fields pick access, width
// - Idle fill after reset; bit selects fill
// - Slot register resets to slot zero
// - Vector and channel interrupt status read zero
// - Four channel masks suppress interrupts; reset unmasked
// - Channel interrupt masks reset to zero
// - Lane bit moves vector to bits 4-7
// - Clock-rate bit: serial clock one or two
// - Driver bit: open-drain or push-pull outputs
// - Frame-length and timing-mode fields in config
// - Address compare: mode, addresses, per-channel enables
// - Active bit enables channel; receiver, loop bits
module hcr_regs
  import hcr_pkg::*;
(
  // Clock and hardware reset
  input wire logic clk,
  input wire logic nrst,
  // Host bus pins
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rw_wr_n,
  input wire logic ds_rd_n,
  input wire logic [6:0] addr,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic [7:0] ad_oe,
  // Interrupt pin, open drain, active low
  output logic int_n_out,
  output logic int_n_oe,
  // Channel events and status from the datapath
  input wire logic [7:0] chan_event [HCR_NCH],
  input wire logic [7:0] chan_status_in [HCR_NCH],
  input wire logic [7:0] rx_count_in [HCR_NCH],
  // Serial side
  input wire logic sclk_tick,
  input wire logic [HCR_NCH-1:0] tx_data,
  input wire logic [HCR_NCH-1:0] tx_drive,
  input wire logic [HCR_NCH-1:0] sd_in,
  output hcr_pin_s [HCR_NCH-1:0] sd_pin,
  output logic [HCR_NCH-1:0] rx_data,
  output logic bit_tick,
  // Configuration to the datapath
  output hcr_ccr_s common_config,
  output hcr_acr_s address_compare_ctrl,
  output hcr_mode_s chan_mode [HCR_NCH],
  output logic [7:0] slot_number [HCR_NCH],
  output logic [7:0] chan_command [HCR_NCH],
  output hcr_style_e bus_style
);

  // Address decode shared by read and write paths
  function automatic logic ch_hit(input logic [6:0] a, input int ch, input logic [2:0] off);
    logic [6:0] base;
    base = 7'(ch) * HCR_CH_STRIDE;
    ch_hit = (a == (base | {4'h0, off}));
  endfunction

  hcr_style_e style_q;
  logic init_q;
  logic ale_seen_q;
  logic [6:0] addr_lat_q;
  logic rd_prev_q;
  logic wr_prev_q;
  hcr_ccr_s ccr_q;
  hcr_acr_s acr_q;
  logic [3:0] channel_vector_mask_q;
  logic [7:0] pend_q [HCR_NCH];
  logic [7:0] ism_q [HCR_NCH];
  logic [7:0] chan_status_q [HCR_NCH];
  logic [7:0] rx_frame_byte_count_q [HCR_NCH];
  hcr_mode_s mode_q [HCR_NCH];
  logic [7:0] tsr_q [HCR_NCH];
  logic [7:0] cmd_q [HCR_NCH];
  logic [7:0] ad_out_q;
  logic [7:0] ad_oe_q;
  logic int_oe_q;
  hcr_pin_s [HCR_NCH-1:0] pin_q;
  logic [HCR_NCH-1:0] rx_q;
  logic half_q;
  logic tick_q;

  logic [6:0] a_eff;
  logic rd_act;
  logic wr_act;
  logic wr_pulse;
  logic rd_end;
  logic [7:0] rdata;
  logic [7:0] rlanes;
  logic [3:0] vec;
  logic [7:0] shown [HCR_NCH];

  // Strap sampled after release; any later edge locks muxed style
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_q <= 1'b0;
      ale_seen_q <= 1'b0;
      style_q <= HCR_STYLE_RWDS;
    end else begin
      init_q <= 1'b1;
      ale_seen_q <= ale;
      if (!init_q) begin
        style_q <= ale ? HCR_STYLE_RWDS : HCR_STYLE_RDWR;
      end else if (ale != ale_seen_q) begin
        style_q <= HCR_STYLE_MUX;
      end
    end
  end

  // Address latch for the multiplexed style
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_lat_q <= 7'h00;
    end else if (ale && style_q == HCR_STYLE_MUX) begin
      addr_lat_q <= ad_in[6:0];
    end
  end

  // Strobe decode per bus style
  always_comb begin
    a_eff = (style_q == HCR_STYLE_MUX) ? addr_lat_q : addr;
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (init_q && !cs_n) begin
      unique case (style_q)
        HCR_STYLE_RWDS: begin
          rd_act = !ds_rd_n && rw_wr_n;
          wr_act = !ds_rd_n && !rw_wr_n;
        end
        HCR_STYLE_RDWR, HCR_STYLE_MUX: begin
          rd_act = !ds_rd_n;
          wr_act = !rw_wr_n;
        end
      endcase
    end
  end

  assign wr_pulse = wr_act && !wr_prev_q;
  assign rd_end = rd_prev_q && !rd_act;

  // Strobe history for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  // Masked view of pending events and the channel vector
  always_comb begin
    for (int i = 0; i < HCR_NCH; i++) begin
      shown[i] = channel_vector_mask_q[i] ? 8'h00 : (pend_q[i] & ~ism_q[i]);
      vec[i] = |shown[i];
    end
  end

  // Common registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccr_q <= hcr_ccr_s'(HCR_RST_ZERO);
      acr_q <= hcr_acr_s'(HCR_RST_ZERO);
      channel_vector_mask_q <= HCR_RST_ZERO[3:0];
    end else if (wr_pulse) begin
      if (a_eff == HCR_ADDR_CCR) ccr_q <= hcr_ccr_s'(ad_in);
      if (a_eff == HCR_ADDR_ACR) acr_q <= hcr_acr_s'(ad_in);
      if (a_eff == HCR_ADDR_CHANNEL_VECTOR_MASK) channel_vector_mask_q <= ad_in[3:0];
    end
  end

  // Per-channel registers
  generate
    for (genvar c = 0; c < HCR_NCH; c++) begin : g_ch
      logic clr;
      assign clr = rd_end && ch_hit(a_eff, c, HCR_OFF_CHAN_IRQ_STATUS);

      // Pending events; a new event wins over a read clear
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pend_q[c] <= HCR_RST_ZERO;
        end else begin
          pend_q[c] <= (pend_q[c] & ~(clr ? shown[c] : 8'h00)) | chan_event[c];
        end
      end

      // Writable channel registers
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ism_q[c] <= HCR_RST_ZERO;
          mode_q[c] <= hcr_mode_s'(HCR_RST_ZERO);
          tsr_q[c] <= HCR_RST_ZERO;
        end else if (wr_pulse) begin
          if (ch_hit(a_eff, c, HCR_OFF_ISM)) ism_q[c] <= ad_in;
          if (ch_hit(a_eff, c, HCR_OFF_MODE)) mode_q[c] <= hcr_mode_s'(ad_in);
          if (ch_hit(a_eff, c, HCR_OFF_TSR)) tsr_q[c] <= ad_in;
        end
      end

      // Command strobe, one cycle per write
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cmd_q[c] <= HCR_RST_ZERO;
        end else begin
          cmd_q[c] <= (wr_pulse && ch_hit(a_eff, c, HCR_OFF_CHAN_COMMAND)) ? ad_in : 8'h00;
        end
      end

      // Status snapshots from the datapath
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          chan_status_q[c] <= HCR_RST_CHAN_STATUS;
          rx_frame_byte_count_q[c] <= HCR_RST_ZERO;
        end else begin
          chan_status_q[c] <= chan_status_in[c];
          rx_frame_byte_count_q[c] <= rx_count_in[c];
        end
      end

      // Serial pin: floating when disabled, open drain drives low only
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pin_q[c] <= '0;
          rx_q[c] <= 1'b0;
        end else begin
          if (!mode_q[c].channel_active || !tx_drive[c]) begin
            pin_q[c] <= '0;
          end else if (ccr_q.driver_type_sel) begin
            pin_q[c] <= '{out: 1'b0, oe: !tx_data[c]};
          end else begin
            pin_q[c] <= '{out: tx_data[c], oe: 1'b1};
          end
          if (mode_q[c].loopback_en) begin
            rx_q[c] <= tx_data[c];
          end else begin
            rx_q[c] <= mode_q[c].receiver_active && sd_in[c];
          end
        end
      end
    end
  endgenerate

  // Read mux with lane selection for the vector
  always_comb begin
    rdata = 8'h00;
    rlanes = 8'hff;
    if (a_eff == HCR_ADDR_CCR) rdata = ccr_q;
    if (a_eff == HCR_ADDR_ACR) rdata = acr_q;
    if (a_eff == HCR_ADDR_CHANNEL_VECTOR_MASK) rdata = {4'h0, channel_vector_mask_q};
    if (a_eff == HCR_ADDR_CHANNEL_VECTOR_STATUS) begin
      rdata = ccr_q.vector_lane_sel ? {vec, 4'h0} : {4'h0, vec};
      rlanes = ccr_q.vector_lane_sel ? HCR_LANE_HI : HCR_LANE_LO;
    end
    for (int i = 0; i < HCR_NCH; i++) begin
      if (ch_hit(a_eff, i, HCR_OFF_CHAN_IRQ_STATUS)) rdata = shown[i];
      if (ch_hit(a_eff, i, HCR_OFF_ISM)) rdata = ism_q[i];
      if (ch_hit(a_eff, i, HCR_OFF_CHAN_STATUS)) rdata = chan_status_q[i];
      if (ch_hit(a_eff, i, HCR_OFF_MODE)) rdata = mode_q[i];
      if (ch_hit(a_eff, i, HCR_OFF_RX_FRAME_BYTE_COUNT)) rdata = rx_frame_byte_count_q[i];
      if (ch_hit(a_eff, i, HCR_OFF_TSR)) rdata = tsr_q[i];
    end
  end

  // Data bus and interrupt pin drivers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ad_out_q <= 8'h00;
      ad_oe_q <= 8'h00;
      int_oe_q <= 1'b0;
    end else begin
      ad_out_q <= rdata;
      ad_oe_q <= rd_act ? rlanes : 8'h00;
      int_oe_q <= |vec;
    end
  end

  // Bit-rate enable: every serial tick or every second one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      if (sclk_tick) half_q <= !half_q;
      tick_q <= sclk_tick && (!ccr_q.clock_ratio_sel || half_q);
    end
  end

  assign ad_out = ad_out_q;
  assign ad_oe = ad_oe_q;
  assign int_n_out = 1'b0;
  assign int_n_oe = int_oe_q;
  assign sd_pin = pin_q;
  assign rx_data = rx_q;
  assign bit_tick = tick_q;
  assign common_config = ccr_q;
  assign address_compare_ctrl = acr_q;
  assign chan_mode = mode_q;
  assign slot_number = tsr_q;
  assign chan_command = cmd_q;
  assign bus_style = style_q;

  // Assertions
  property p_mux_sticky;
    @(posedge clk) disable iff (!nrst)
      style_q == HCR_STYLE_MUX |=> style_q == HCR_STYLE_MUX;
  endproperty
  a_mux_sticky: assert property (p_mux_sticky) else $error("mux style left");

  property p_edge_mux;
    @(posedge clk) disable iff (!nrst)
      init_q && (ale != ale_seen_q) |=> style_q == HCR_STYLE_MUX;
  endproperty
  a_edge_mux: assert property (p_edge_mux) else $error("strap edge ignored");

  property p_write_ccr;
    @(posedge clk) disable iff (!nrst)
      wr_pulse && a_eff == HCR_ADDR_CCR |=> ccr_q == $past(ad_in);
  endproperty
  a_write_ccr: assert property (p_write_ccr) else $error("ccr write lost");

  property p_lane_hi;
    @(posedge clk) disable iff (!nrst)
      rd_act && a_eff == HCR_ADDR_CHANNEL_VECTOR_STATUS && ccr_q.vector_lane_sel |=> ad_oe == HCR_LANE_HI;
  endproperty
  a_lane_hi: assert property (p_lane_hi) else $error("vector lane wrong");

  property p_idle_float;
    @(posedge clk) disable iff (!nrst)
      !rd_act |=> ad_oe == 8'h00;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("bus driven when idle");

  property p_disabled_float;
    @(posedge clk) disable iff (!nrst)
      !mode_q[0].channel_active |=> !sd_pin[0].oe;
  endproperty
  a_disabled_float: assert property (p_disabled_float) else $error("disabled ch drives");

  property p_open_drain;
    @(posedge clk) disable iff (!nrst)
      ccr_q.driver_type_sel && tx_drive[1] && mode_q[1].channel_active
        |=> !sd_pin[1].out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_mask_int;
    @(posedge clk) disable iff (!nrst)
      channel_vector_mask_q == 4'hf |=> !int_n_oe;
  endproperty
  a_mask_int: assert property (p_mask_int) else $error("masked irq shown");

  property p_event_kept;
    @(posedge clk) disable iff (!nrst)
      chan_event[2] != 8'h00 |=> (pend_q[2] & $past(chan_event[2])) == $past(chan_event[2]);
  endproperty
  a_event_kept: assert property (p_event_kept) else $error("event lost");

  property p_ratio_two;
    @(posedge clk) disable iff (!nrst)
      ccr_q.clock_ratio_sel && tick_q ##1 ccr_q.clock_ratio_sel[*1] |-> !tick_q;
  endproperty
  a_ratio_two: assert property (p_ratio_two) else $error("ticks too close");

  c_mux: cover property (@(posedge clk) disable iff (!nrst) style_q == HCR_STYLE_MUX);
  c_irq: cover property (@(posedge clk) disable iff (!nrst) int_n_oe ##[1:20] !int_n_oe);
  c_drive: cover property (@(posedge clk) disable iff (!nrst) sd_pin[0].oe);

endmodule

// ===== tb/hcr_host.sv
// Host microcontroller model on the separate read/write strobe bus
module hcr_host
  import hcr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus pins towards the device
  output logic cs_n,
  output logic rw_wr_n,
  output logic ds_rd_n,
  output logic [6:0] addr,
  output logic [7:0] ad_in,
  // Read data from the device
  input wire logic [7:0] ad_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rw_wr_n = 1'b1;
    ds_rd_n = 1'b1;
    addr = 7'h00;
    ad_in = 8'h00;
  end

  // Write: strobe held one edge, then two idle cycles so registered effects settle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rw_wr_n <= 1'b0;
    addr <= a;
    ad_in <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    rw_wr_n <= 1'b1;
    ad_in <= ~d; // Released bus stops showing the data
    @(posedge clk);
    @(posedge clk);
  endtask

  // Read: data taken one edge after the device answers
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    ds_rd_n <= 1'b0;
    addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = ad_out;
    cs_n <= 1'b1;
    ds_rd_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// ===== tb/hdlc_controller_config_regs_bench.sv
// Self-checking bench of the configuration register bank
module hdlc_controller_config_regs_bench;
  import hcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, ale, cs_n, rw_wr_n, ds_rd_n, int_n_out, int_n_oe, sclk_tick, bit_tick;
  logic [6:0] addr;
  logic [7:0] ad_in, ad_out, ad_oe;
  logic [7:0] chan_event [HCR_NCH];
  logic [7:0] chan_status_in [HCR_NCH];
  logic [7:0] rx_count_in [HCR_NCH];
  logic [7:0] slot_number [HCR_NCH];
  logic [7:0] chan_command [HCR_NCH];
  logic [HCR_NCH-1:0] tx_data, tx_drive, sd_in, rx_data;
  logic [1:0] tick_cnt;
  hcr_pin_s [HCR_NCH-1:0] sd_pin;
  hcr_ccr_s common_config;
  hcr_acr_s address_compare_ctrl;
  hcr_mode_s chan_mode [HCR_NCH];
  hcr_style_e bus_style;
  int n_errors = 0;
  int samples_checked = 0;

  hcr_regs i_dut (.clk(clk), .nrst(nrst), .ale(ale), .cs_n(cs_n), .rw_wr_n(rw_wr_n),
    .ds_rd_n(ds_rd_n), .addr(addr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .chan_event(chan_event),
    .chan_status_in(chan_status_in), .rx_count_in(rx_count_in), .sclk_tick(sclk_tick),
    .tx_data(tx_data), .tx_drive(tx_drive), .sd_in(sd_in), .sd_pin(sd_pin),
    .rx_data(rx_data), .bit_tick(bit_tick), .common_config(common_config), .address_compare_ctrl(address_compare_ctrl), .chan_mode(chan_mode),
    .slot_number(slot_number), .chan_command(chan_command), .bus_style(bus_style));

  hcr_host i_host (.clk(clk), .cs_n(cs_n), .rw_wr_n(rw_wr_n), .ds_rd_n(ds_rd_n),
    .addr(addr), .ad_in(ad_in), .ad_out(ad_out));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Serial clock pulse every fourth cycle
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sclk_tick <= (tick_cnt == 2'h3);
  end

  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register read compared against an expected value
  task automatic rc(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(what, d, exp);
  endtask

  function automatic logic [6:0] ca(input int c, input logic [2:0] off);
    return 7'(c) * HCR_CH_STRIDE + {4'h0, off};
  endfunction

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input int c, input logic [7:0] e);
    @(posedge clk);
    chan_event[c] <= e;
    @(posedge clk);
    chan_event[c] <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  // Pins, outputs and every register after reset
  task automatic t_reset();
    chk("ad_oe", ad_oe, 8'h00);
    chk("int_n_oe", {7'h0, int_n_oe}, 8'h00);
    chk("style", {6'h0, bus_style}, {6'h0, HCR_STYLE_RDWR});
    chk("ccr", common_config, HCR_RST_ZERO);
    chk("acr", address_compare_ctrl, HCR_RST_ZERO);
    for (int c = 0; c < HCR_NCH; c++) begin
      chk("sd oe", {7'h0, sd_pin[c].oe}, 8'h00);
      chk("mode", chan_mode[c], HCR_RST_ZERO);
      chk("cmd", chan_command[c], HCR_RST_ZERO);
      rc("chan_irq_status", ca(c, HCR_OFF_CHAN_IRQ_STATUS), 8'h00);
      rc("ism", ca(c, HCR_OFF_ISM), 8'h00);
      rc("chan_status", ca(c, HCR_OFF_CHAN_STATUS), HCR_RST_CHAN_STATUS);
      rc("mode rd", ca(c, HCR_OFF_MODE), 8'h00);
      rc("rx_frame_byte_count", ca(c, HCR_OFF_RX_FRAME_BYTE_COUNT), 8'h00);
      rc("tsr", ca(c, HCR_OFF_TSR), 8'h00);
    end
    rc("channel_vector_status", HCR_ADDR_CHANNEL_VECTOR_STATUS, 8'h00);
    rc("channel_vector_mask", HCR_ADDR_CHANNEL_VECTOR_MASK, 8'h00);
    rc("ccr rd", HCR_ADDR_CCR, 8'h00);
    rc("acr rd", HCR_ADDR_ACR, 8'h00);
    rc("unmapped", 7'h7f, 8'h00);
  endtask

  // Common registers first, then each channel
  task automatic t_init();
    i_host.wr(HCR_ADDR_CCR, 8'h5e);
    i_host.wr(HCR_ADDR_CHANNEL_VECTOR_MASK, 8'h00);
    i_host.wr(HCR_ADDR_ACR, 8'ha5);
    chk("ccr", common_config, 8'h5e);
    chk("acr", address_compare_ctrl, 8'ha5);
    rc("ccr rd", HCR_ADDR_CCR, 8'h5e);
    rc("acr rd", HCR_ADDR_ACR, 8'ha5);
    for (int c = 0; c < HCR_NCH; c++) begin
      i_host.wr(ca(c, HCR_OFF_MODE), 8'h98 | 8'(c));
      i_host.wr(ca(c, HCR_OFF_TSR), 8'hf0 + 8'(c));
      i_host.wr(ca(c, HCR_OFF_CHAN_COMMAND), 8'h3c);
      chk("mode", chan_mode[c], 8'h98 | 8'(c));
      chk("slot", slot_number[c], 8'hf0 + 8'(c));
      rc("mode rd", ca(c, HCR_OFF_MODE), 8'h98 | 8'(c));
      rc("cmd rd", ca(c, HCR_OFF_CHAN_COMMAND), 8'h00);
      i_host.wr(ca(c, HCR_OFF_MODE), 8'h00);
    end
  endtask

  // Bit pulses over 64 cycles for a given clock ratio
  task automatic t_rate(input logic [7:0] cfg, input int exp);
    int n;
    n = 0;
    i_host.wr(HCR_ADDR_CCR, cfg);
    repeat (16) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      if (bit_tick === 1'b1) n++;
    end
    chk("bit_tick count", 8'(n), 8'(exp));
  endtask

  // Vector lanes, channel masks and read clear
  task automatic t_irq();
    i_host.wr(HCR_ADDR_CCR, 8'h00);
    pulse(1, 8'h01);
    chk("int", {7'h0, int_n_oe}, 8'h01);
    rc("channel_vector_status lo", HCR_ADDR_CHANNEL_VECTOR_STATUS, 8'h02);
    rc("chan_irq_status", ca(1, HCR_OFF_CHAN_IRQ_STATUS), 8'h01);
    rc("chan_irq_status clr", ca(1, HCR_OFF_CHAN_IRQ_STATUS), 8'h00);
    chk("int clr", {7'h0, int_n_oe}, 8'h00);
    i_host.wr(HCR_ADDR_CCR, 8'h40);
    i_host.wr(HCR_ADDR_CHANNEL_VECTOR_MASK, 8'h08);
    pulse(3, 8'h02);
    chk("int vmask", {7'h0, int_n_oe}, 8'h00);
    rc("channel_vector_status masked", HCR_ADDR_CHANNEL_VECTOR_STATUS, 8'h00);
    i_host.wr(HCR_ADDR_CHANNEL_VECTOR_MASK, 8'h00);
    chk("int unmask", {7'h0, int_n_oe}, 8'h01);
    rc("channel_vector_status hi", HCR_ADDR_CHANNEL_VECTOR_STATUS, 8'h80);
    rc("chan_irq_status", ca(3, HCR_OFF_CHAN_IRQ_STATUS), 8'h02);
    i_host.wr(ca(0, HCR_OFF_ISM), 8'h10);
    pulse(0, 8'h10);
    chk("int ism", {7'h0, int_n_oe}, 8'h00);
    i_host.wr(ca(0, HCR_OFF_ISM), 8'h00);
    chk("int ism off", {7'h0, int_n_oe}, 8'h01);
    rc("chan_irq_status", ca(0, HCR_OFF_CHAN_IRQ_STATUS), 8'h10);
  endtask

  // Channel activity, driver type and test loop on channel 0
  task automatic t_pins();
    tx_drive <= 4'h1;
    tx_data <= 4'h1;
    i_host.wr(HCR_ADDR_CCR, 8'h00);
    chk("oe off", {7'h0, sd_pin[0].oe}, 8'h00);
    i_host.wr(ca(0, HCR_OFF_MODE), 8'h40);
    chk("pp one", {6'h0, sd_pin[0]}, 8'h03);
    i_host.wr(HCR_ADDR_CCR, 8'h04);
    chk("od one", {7'h0, sd_pin[0].oe}, 8'h00);
    i_host.wr(ca(0, HCR_OFF_MODE), 8'h60);
    tx_data <= 4'h0;
    repeat (4) @(posedge clk);
    chk("loop", {7'h0, rx_data[0]}, 8'h00);
    tx_data <= 4'h1;
    repeat (4) @(posedge clk);
    chk("loop", {7'h0, rx_data[0]}, 8'h01);
    tx_drive <= 4'h0;
  endtask

  // Strap edge selects the multiplexed style until reset
  task automatic t_style();
    ale <= 1'b1;
    @(posedge clk);
    ale <= 1'b0;
    repeat (3) @(posedge clk);
    chk("style mux", {6'h0, bus_style}, {6'h0, HCR_STYLE_MUX});
    ale <= 1'b1;
    do_reset();
    chk("style rwds", {6'h0, bus_style}, {6'h0, HCR_STYLE_RWDS});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ale = 1'b0;
    tick_cnt = 2'h0;
    sclk_tick = 1'b0;
    tx_data = 4'h0;
    tx_drive = 4'h0;
    sd_in = 4'h0;
    for (int c = 0; c < HCR_NCH; c++) begin
      chan_event[c] = 8'h00;
      chan_status_in[c] = HCR_RST_CHAN_STATUS;
      rx_count_in[c] = 8'h00;
    end
    do_reset();
    t_reset();
    t_init();
    t_rate(8'h00, 16);
    t_rate(8'h08, 8);
    t_irq();
    t_pins();
    t_style();
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
